// ===== bench/camera_pixel_capture_path_bench.sv
// Purpose: Self-checking bench of the capture path
// Assumes: sys_clk 20 MHz, reader clock 33 MHz, table loaded with 16 entries
// Notes: Expected words come from the bench's own table function
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module camera_pixel_capture_path_bench;
  logic sys_clk, rst, reg_wr, reg_rd, fifo_clk, fifo_rst, fifo_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fifo_data, rv;
  logic [15:0] cam_pix;
  logic cam_lv, cam_fv, cam_pclk, pclk_o, pclk_oe_n, fifo_valid, fifo_empty;
  wire pclk_w;
  int n_mismatch = 0;
  int cmp_count = 0;
  localparam int EN = 1 << `CPC_B_EN;

  // Wire level of the two-way clock pin
  assign pclk_w = pclk_oe_n ? cam_pclk : pclk_o;

  cpc_top i_cpc_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(cam_pix), .line_valid(cam_lv),
    .frame_valid(cam_fv), .pclk_i(pclk_w), .pclk_o(pclk_o), .pclk_oe_n(pclk_oe_n), .fifo_clk(fifo_clk),
    .fifo_rst(fifo_rst), .fifo_rd(fifo_rd), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
    .fifo_empty(fifo_empty));
  cpc_cam_model i_cpc_cam_model (.pix(cam_pix), .line_v(cam_lv), .frame_v(cam_fv), .pclk(cam_pclk));

  // ----------------------------------------
  // Clocks and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Reader clock unrelated to sys_clk, below the 50 MHz ceiling
  initial begin
    fifo_clk = 1'b0;
    forever #15 fifo_clk = ~fifo_clk;
  end
  // Whole run needs about 40 us
  initial begin
    #1_000_000;
    n_mismatch++;
    conclude();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  function automatic cpc_pkg::cpc_pix_t lutv(input logic [15:0] i);
    return 16'h1111 * i + 16'h0305;
  endfunction : lutv

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Pops one word; the wait is bounded so a dead buffer cannot hang the run
  task automatic fifo_pop(input cpc_pkg::cpc_word_t exp);
    int w;
    w = 0;
    do begin
      @(posedge fifo_clk);
      #1 w++;
    end while (fifo_empty !== 1'b0 && w < 400);
    @(posedge fifo_clk);
    fifo_rd <= 1'b1;
    @(posedge fifo_clk);
    fifo_rd <= 1'b0;
    #1 check(32'(fifo_valid), 32'h0000_0001);
    check(fifo_data, exp);
  endtask : fifo_pop

  // Clears any partial word, captures one frame, drains and expects an empty buffer
  task automatic capture(input logic [31:0] ctrl, input cpc_pkg::cpc_pix_t p [4], input int n,
                         input cpc_pkg::cpc_word_t e [2]);
    reg_write(`CPC_REG_CTRL, 32'h0000_0000);
    reg_write(`CPC_REG_CTRL, ctrl);
    i_cpc_cam_model.frame(p, ctrl[`CPC_B_FALL], ctrl[`CPC_B_LVLOW]);
    repeat (10) @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      fifo_pop(e[k]);
    end
    repeat (10) @(posedge fifo_clk);
    #1 check(32'(fifo_empty), 32'h0000_0001);
  endtask : capture

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] a [6] = '{`CPC_REG_CTRL, `CPC_REG_MASK, `CPC_REG_WIDTH, `CPC_REG_HEIGHT, `CPC_REG_STAT, 8'h3C};
    logic [31:0] e [6] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_2000, 32'h0000_2000, 32'h0000_0000, 32'h0};
    #1 check(32'(pclk_oe_n), 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      reg_read(a[k], rv);
      check(rv, e[k]);
    end
    $display("reset done");
  endtask : t_reset

  // Only the sixteen lowest entries are loaded
  task automatic t_lut();
    reg_write(`CPC_REG_LUTA, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      reg_write(`CPC_REG_LUTD, {16'h0000, lutv(16'(k))});
    end
    reg_read(`CPC_REG_LUTA, rv);
    check(rv, 32'h0000_0010);
    $display("table done");
  endtask : t_lut

  task automatic t_paths();
    capture(EN, '{1, 2, 3, 4}, 2, '{{lutv(2), lutv(1)}, {lutv(4), lutv(3)}});
    capture(EN | (1 << `CPC_B_PK8), '{5, 6, 7, 8}, 1,
            '{{8'(lutv(8)), 8'(lutv(7)), 8'(lutv(6)), 8'(lutv(5))}, 32'h0});
    reg_write(`CPC_REG_MASK, 32'h0000_000F);
    capture(EN, '{16'hFF01, 16'h1232, 16'h0003, 16'hABC4}, 2,
            '{{lutv(2), lutv(1)}, {lutv(4), lutv(3)}});
    reg_write(`CPC_REG_MASK, 32'h0000_FFFF);
    reg_write(`CPC_REG_SHIFT, 32'h0000_000C);
    capture(EN | (1 << `CPC_B_MSB), '{16'h1000, 16'h2000, 16'h3000, 16'hF000}, 2,
            '{{lutv(2), lutv(1)}, {lutv(15), lutv(3)}});
    reg_write(`CPC_REG_SHIFT, 32'h0000_0000);
    reg_write(`CPC_REG_MASK, 32'h0000_0000);
    capture(EN | (1 << `CPC_B_TAP2), '{9, 10, 11, 12}, 2,
            '{{lutv(10), lutv(9)}, {lutv(12), lutv(11)}});
    reg_write(`CPC_REG_MASK, 32'h0000_FFFF);
    capture(EN | (1 << `CPC_B_FALL) | (1 << `CPC_B_LVLOW) | (1 << `CPC_B_FVLOW), '{13, 14, 1, 2}, 2,
            '{{lutv(14), lutv(13)}, {lutv(2), lutv(1)}});
    $display("paths done");
  endtask : t_paths

  task automatic t_window();
    reg_write(`CPC_REG_XSTART, 32'h0000_0001);
    reg_write(`CPC_REG_WIDTH, 32'h0000_0002);
    capture(EN | (1 << `CPC_B_ROI), '{3, 5, 7, 9}, 1, '{{lutv(7), lutv(5)}, 32'h0});
    capture(EN | (1 << `CPC_B_SUB) | (1 << `CPC_B_SUBSEL), '{3, 5, 7, 9}, 1,
            '{{lutv(7), lutv(3)}, 32'h0});
    reg_read(`CPC_REG_STAT, rv);
    check(rv, 32'h0000_0000);
    $display("window done");
  endtask : t_window

  // 2.5 MHz from a 20 MHz clock is four cycles high
  task automatic t_clkout();
    int n;
    int w;
    n = 0;
    w = 0;
    reg_write(`CPC_REG_CTRL, EN | (1 << `CPC_B_CKOUT) | (4 << `CPC_B_FSEL));
    repeat (4) @(posedge sys_clk);
    #1 check(32'(pclk_oe_n), 32'h0000_0000);
    while (pclk_o !== 1'b0 && w < 100) begin
      @(posedge sys_clk);
      #1 w++;
    end
    while (pclk_o !== 1'b1 && w < 200) begin
      @(posedge sys_clk);
      #1 w++;
    end
    while (pclk_o === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check(32'(n), 32'h0000_0004);
    reg_write(`CPC_REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    #1 check(32'(pclk_oe_n), 32'h0000_0001);
    $display("clock out done");
  endtask : t_clkout

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    fifo_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    fifo_rd = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    fifo_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_lut();
    t_paths();
    t_window();
    t_clkout();
    conclude();
  end
endmodule : camera_pixel_capture_path_bench
`default_nettype wire

// ===== bench/cpc_cam_model.sv
// Purpose: Camera side of the pixel link, one line of four pixels per frame
// Assumes: Pixel clock of 400 ns made here, active edge chosen per frame
// Notes: Clock stands still outside frames; released data shows the inverse
`timescale 1ns/1ps
`default_nettype none
module cpc_cam_model (
  output logic [15:0] pix,
  output logic line_v,
  output logic frame_v,
  output logic pclk
);
  // Idle levels until the first frame
  initial begin
    pix = 16'h0000;
    line_v = 1'b0;
    frame_v = 1'b0;
    pclk = 1'b0;
  end

  // ----------------------------------------
  // One frame
  // ----------------------------------------
  // Data is held 200 ns on both sides of the active edge, so the sampler has margin
  task automatic frame(input cpc_pkg::cpc_pix_t p [4], input logic fall, input logic alow);
    line_v = alow;
    frame_v = alow;
    #800;
    frame_v = ~alow;
    #400;
    line_v = ~alow;
    for (int k = 0; k < 4; k++) begin
      pclk = fall;
      pix = p[k];
      #200;
      pclk = ~fall; // 2.5 MHz, under both rate ceilings
      #200;
    end
    pclk = 1'b0;
    pix = ~pix;
    line_v = alow;
    #800;
    frame_v = alow;
  endtask : frame
endmodule : cpc_cam_model
`default_nettype wire

// ===== rtl/cpc_fifo.sv
// Purpose: 16384 x 32 dual-clock buffer between packer and reading board
// Assumes: Reader drains continuously on its own clock
// Notes: Gray pointers cross the domains; words offered while full are not taken
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module cpc_fifo (
  input wire logic wr_clk,
  input wire logic wr_rst,
  cpc_wr_if.snk wr,
  input wire logic rd_clk,
  input wire logic rd_rst,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic rd_empty
);
  localparam int AW = `CPC_FIFO_AW;
  logic [31:0] mem [0:(1 << AW) - 1];
  logic [AW:0] wbin, wgray, r2w1, r2w2;
  logic [AW:0] rbin, rgray, w2r1, w2r2;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
    g2b = b;
  endfunction : g2b

  // ----------------------------------------
  // Write side
  // ----------------------------------------
  wire [AW:0] wbin_nx = wbin + 1'b1;
  wire full = (wgray == {~r2w2[AW:AW - 1], r2w2[AW - 2:0]});
  wire do_wr = wr.valid && !full;
  assign wr.ready = !full; // No overwrite: full refuses
  assign wr.level = cpc_pkg::cpc_level_t'(wbin - g2b(r2w2));

  // Store 32-bit words, deep enough to ride out bus latency
  always_ff @(posedge wr_clk) begin
    if (do_wr) mem[wbin[AW - 1:0]] <= wr.data;
  end

  // Write pointer and read-pointer synchroniser
  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin <= '0;
      wgray <= '0;
      r2w1 <= '0;
      r2w2 <= '0;
    end else begin
      r2w1 <= rgray;
      r2w2 <= r2w1;
      if (do_wr) begin
        wbin <= wbin_nx;
        wgray <= wbin_nx ^ (wbin_nx >> 1);
      end
    end
  end

  // ----------------------------------------
  // Read side, one word per read cycle
  // ----------------------------------------
  wire do_rd = rd_en && !rd_empty;
  wire [AW:0] rbin_nx = do_rd ? rbin + 1'b1 : rbin;
  wire [AW:0] rgray_nx = rbin_nx ^ (rbin_nx >> 1);

  // Empty may lag a fresh write by the sync delay; never early
  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin <= '0;
      rgray <= '0;
      w2r1 <= '0;
      w2r2 <= '0;
      rd_empty <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      w2r1 <= wgray;
      w2r2 <= w2r1;
      rbin <= rbin_nx;
      rgray <= rgray_nx;
      rd_empty <= (rgray_nx == w2r2);
      rd_valid <= do_rd;
      if (do_rd) rd_data <= mem[rbin[AW - 1:0]];
    end
  end

  AST_FIFO_NO_WR_FULL: assert property (@(posedge wr_clk) disable iff (wr_rst)
    full |=> $stable(wbin)) else $error("write pointer moved while full");
  AST_FIFO_RD_ONE: assert property (@(posedge rd_clk) disable iff (rd_rst)
    rd_en && !rd_empty |=> rd_valid && rbin == $past(rbin) + 1'b1) else $error("read not one word");
endmodule : cpc_fifo
`default_nettype wire

// ===== rtl/cpc_params.svh
// Purpose: Offsets, field positions, reset values and clock rates of the capture path
// Assumes: Included by bare name; definitions only
// Notes: Offsets are byte addresses on the plain register port
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
// ----------------------------------------
// Clock and generated pixel clock set
// ----------------------------------------
`define CPC_SYS_KHZ 20000
`define CPC_F0_KHZ 250
`define CPC_F1_KHZ 500
`define CPC_F2_KHZ 1000
`define CPC_F3_KHZ 2000
`define CPC_F4_KHZ 2500
`define CPC_F5_KHZ 5000
`define CPC_F6_KHZ 10000
`define CPC_F7_KHZ 50000
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CPC_REG_CTRL 8'h00
`define CPC_REG_MASK 8'h04
`define CPC_REG_SHIFT 8'h08
`define CPC_REG_XSTART 8'h0C
`define CPC_REG_YSTART 8'h10
`define CPC_REG_WIDTH 8'h14
`define CPC_REG_HEIGHT 8'h18
`define CPC_REG_LUTA 8'h1C
`define CPC_REG_LUTD 8'h20
`define CPC_REG_STAT 8'h24
// ----------------------------------------
// Control and status field positions
// ----------------------------------------
`define CPC_B_EN 0
`define CPC_B_MSB 1
`define CPC_B_CKOUT 2
`define CPC_B_FALL 3
`define CPC_B_ROI 4
`define CPC_B_SUB 5
`define CPC_B_LVLOW 6
`define CPC_B_FVLOW 7
`define CPC_B_PK8 8
`define CPC_B_TAP2 9
`define CPC_B_FSEL 10
`define CPC_B_SUBSEL 13
`define CPC_S_OVF 0
`define CPC_S_FULL 1
`define CPC_S_LEVEL 16
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define CPC_CTRL_RST 15'h0000
`define CPC_MASK_RST 16'hFFFF
`define CPC_WIN_RST 16'h2000
`define CPC_FIFO_AW 14
`endif

// ===== rtl/cpc_pkg.sv
// Purpose: Shared types of the capture path
// Assumes: Nothing is imported; users write cpc_pkg::name
// Notes: Numbers live in cpc_params.svh
package cpc_pkg;
  typedef logic [15:0] cpc_pix_t;
  typedef logic [31:0] cpc_word_t;
  typedef logic [14:0] cpc_level_t;
endpackage : cpc_pkg

// ===== rtl/cpc_top.sv
// Purpose: Camera pixel capture path: pins, window, decimation, table, packer, buffer
// Assumes: sys_clk 20 MHz; camera pins asynchronous, sampled by two flip-flops
// Notes: Pixel clock seen by sampling, so camera rates must stay well below sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module cpc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] pix_in,
  input wire logic line_valid,
  input wire logic frame_valid,
  input wire logic pclk_i,
  output logic pclk_o,
  output logic pclk_oe_n,
  input wire logic fifo_clk,
  input wire logic fifo_rst,
  input wire logic fifo_rd,
  output logic [31:0] fifo_data,
  output logic fifo_valid,
  output logic fifo_empty
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [14:0] ctrl;
  cpc_pkg::cpc_pix_t mask;
  logic [3:0] shift;
  cpc_pkg::cpc_pix_t xs, ys, win_w, win_h;
  cpc_pkg::cpc_pix_t lut_addr;
  logic ovf;

  wire en = ctrl[`CPC_B_EN];
  wire msb = ctrl[`CPC_B_MSB];
  wire ckout = ctrl[`CPC_B_CKOUT];
  wire fall = ctrl[`CPC_B_FALL];
  wire roi_en = ctrl[`CPC_B_ROI];
  wire sub_en = ctrl[`CPC_B_SUB];
  wire lv_low = ctrl[`CPC_B_LVLOW];
  wire fv_low = ctrl[`CPC_B_FVLOW];
  wire pk8 = ctrl[`CPC_B_PK8];
  wire tap2 = ctrl[`CPC_B_TAP2];
  wire [2:0] fsel = ctrl[`CPC_B_FSEL +: 3];
  wire [1:0] sub_sel = ctrl[`CPC_B_SUBSEL +: 2];

  cpc_wr_if wr ();

  // Address decode
  wire wr_ctrl = reg_wr && reg_addr == `CPC_REG_CTRL;
  wire wr_mask = reg_wr && reg_addr == `CPC_REG_MASK;
  wire wr_shift = reg_wr && reg_addr == `CPC_REG_SHIFT;
  wire wr_xs = reg_wr && reg_addr == `CPC_REG_XSTART;
  wire wr_ys = reg_wr && reg_addr == `CPC_REG_YSTART;
  wire wr_w = reg_wr && reg_addr == `CPC_REG_WIDTH;
  wire wr_h = reg_wr && reg_addr == `CPC_REG_HEIGHT;
  wire wr_luta = reg_wr && reg_addr == `CPC_REG_LUTA;
  wire wr_lutd = reg_wr && reg_addr == `CPC_REG_LUTD;
  wire wr_stat = reg_wr && reg_addr == `CPC_REG_STAT;

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= `CPC_CTRL_RST;
      mask <= `CPC_MASK_RST;
      shift <= 4'h0;
      xs <= 16'h0000;
      ys <= 16'h0000;
      win_w <= `CPC_WIN_RST;
      win_h <= `CPC_WIN_RST;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata[14:0];
      if (wr_mask) mask <= reg_wdata[15:0];
      if (wr_shift) shift <= reg_wdata[3:0];
      if (wr_xs) xs <= reg_wdata[15:0];
      if (wr_ys) ys <= reg_wdata[15:0];
      if (wr_w) win_w <= reg_wdata[15:0];
      if (wr_h) win_h <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------
  // Lookup table, loaded through an auto-incrementing address
  // ----------------------------------------
  // Any mapping is allowed: gamma, MSB rotation, byte cropping
  logic [15:0] lut [0:65535];

  always_ff @(posedge sys_clk) begin
    if (wr_lutd) lut[lut_addr] <= reg_wdata[15:0];
  end

  // Loading only low entries is fine; the rest stay unused
  always_ff @(posedge sys_clk) begin
    if (rst) lut_addr <= 16'h0000;
    else if (wr_luta) lut_addr <= reg_wdata[15:0];
    else if (wr_lutd) lut_addr <= lut_addr + 16'h0001;
  end

  // ----------------------------------------
  // Pixel clock generator
  // ----------------------------------------
  // Rates above sys_clk/2 cannot be made here and clamp to the fastest one
  function automatic logic [5:0] half_cnt(input logic [2:0] sel);
    int khz;
    case (sel)
      3'h0: khz = `CPC_F0_KHZ;
      3'h1: khz = `CPC_F1_KHZ;
      3'h2: khz = `CPC_F2_KHZ;
      3'h3: khz = `CPC_F3_KHZ;
      3'h4: khz = `CPC_F4_KHZ;
      3'h5: khz = `CPC_F5_KHZ;
      3'h6: khz = `CPC_F6_KHZ;
      default: khz = `CPC_F7_KHZ;
    endcase
    half_cnt = (`CPC_SYS_KHZ / (2 * khz) < 1) ? 6'h01 : 6'(`CPC_SYS_KHZ / (2 * khz));
  endfunction : half_cnt

  logic [5:0] ck_cnt;
  wire [5:0] ck_half = half_cnt(fsel);
  wire ck_wrap = (ck_cnt + 6'h01) >= ck_half;

  // Drive the pin only in output mode; enable is active low
  always_ff @(posedge sys_clk) begin
    if (rst || !ckout) begin
      ck_cnt <= 6'h00;
      pclk_o <= 1'b0;
      pclk_oe_n <= 1'b1;
    end else begin
      pclk_oe_n <= 1'b0;
      ck_cnt <= ck_wrap ? 6'h00 : ck_cnt + 6'h01;
      if (ck_wrap) pclk_o <= ~pclk_o;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic ps1, ps2, ps3;
  cpc_pkg::cpc_pix_t d1, d2;
  logic lv1, lv2, fv1, fv2;

  // Driven clock takes the same path as a received one, so data alignment matches
  always_ff @(posedge sys_clk) begin
    ps1 <= ckout ? pclk_o : pclk_i;
    ps2 <= ps1;
    ps3 <= ps2;
    d1 <= pix_in;
    d2 <= d1;
    lv1 <= line_valid;
    lv2 <= lv1;
    fv1 <= frame_valid;
    fv2 <= fv1;
  end

  wire p_rise = ps2 && !ps3;
  wire p_fall = !ps2 && ps3;
  wire pedge = fall ? p_fall : p_rise;
  wire lv_a = lv2 ^ lv_low;
  wire fv_a = fv2 ^ fv_low;

  // ----------------------------------------
  // Pixel and line counters
  // ----------------------------------------
  cpc_pkg::cpc_pix_t x, y;
  logic lv_p;

  // Max rate depends on sampling, not on window use here
  // Ends of lines and frames act on levels: a clock that stops between frames still zeroes the counts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      x <= 16'h0000;
      y <= 16'h0000;
      lv_p <= 1'b0;
    end else begin
      lv_p <= lv_a;
      if (!fv_a) begin
        x <= 16'h0000;
        y <= 16'h0000;
      end else if (!lv_a) begin
        x <= 16'h0000;
        if (lv_p) y <= y + 16'h0001;
      end else if (pedge) begin
        x <= x + 16'h0001;
      end
    end
  end

  // Window and decimation, each enabled on its own
  wire [15:0] dx = x - xs;
  wire [15:0] dy = y - ys;
  wire in_win = x >= xs && dx < win_w && y >= ys && dy < win_h;
  wire [15:0] sub_m = 16'((16'h0001 << sub_sel) - 16'h0001);
  wire keep_sub = (x & sub_m) == 16'h0000 && (y & sub_m) == 16'h0000;
  wire take = en && pedge && fv_a && lv_a && (!roi_en || in_win) && (!sub_en || keep_sub);

  // ----------------------------------------
  // Index forming, table read, packing
  // ----------------------------------------
  wire [15:0] masked = d2 & mask;
  wire [15:0] aligned = msb ? masked >> shift : masked;
  wire [15:0] next_idx = tap2 ? d2 : aligned; // Both tap bytes form the index

  cpc_pkg::cpc_pix_t idx, lut_q;
  logic v1, v2;

  // Capture first, then table, then packer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      v1 <= 1'b0;
      v2 <= 1'b0;
    end else begin
      v1 <= take;
      v2 <= v1;
    end
  end

  always_ff @(posedge sys_clk) begin
    idx <= next_idx;
    lut_q <= lut[idx];
  end

  logic [1:0] pk_cnt;
  cpc_pkg::cpc_word_t pk_word, next_word, out_word;
  logic push;
  wire last = pk8 ? pk_cnt == 2'h3 : pk_cnt[0];

  // Earliest pixel in the lowest lane
  always_comb begin
    next_word = pk_word;
    if (pk8) next_word[pk_cnt * 8 +: 8] = lut_q[7:0];
    else next_word[pk_cnt[0] * 16 +: 16] = lut_q;
  end

  // Only a completely filled word is offered to the buffer
  always_ff @(posedge sys_clk) begin
    if (rst || !en) begin
      pk_cnt <= 2'h0;
      pk_word <= 32'h0000_0000;
      push <= 1'b0;
    end else begin
      push <= v2 && last;
      if (v2) begin
        pk_word <= last ? 32'h0000_0000 : next_word;
        pk_cnt <= last ? 2'h0 : pk_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (v2 && last) out_word <= next_word;
  end

  assign wr.valid = push;
  assign wr.data = out_word;

  // Sticky overflow; a new drop wins over a clear in the same cycle
  wire ovf_set = push && !wr.ready;
  wire ovf_clr = wr_stat && reg_wdata[`CPC_S_OVF];

  always_ff @(posedge sys_clk) begin
    if (rst) ovf <= 1'b0;
    else ovf <= ovf_set || (ovf && !ovf_clr);
  end

  // ----------------------------------------
  // Buffer toward the reading board
  // ----------------------------------------
  // Not a frame store: the reader must keep draining
  cpc_fifo u_fifo (
    .wr_clk(sys_clk),
    .wr_rst(rst),
    .wr(wr),
    .rd_clk(fifo_clk),
    .rd_rst(fifo_rst),
    .rd_en(fifo_rd),
    .rd_data(fifo_data),
    .rd_valid(fifo_valid),
    .rd_empty(fifo_empty)
  );

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  wire [31:0] stat_w = {1'b0, wr.level, 14'h0000, !wr.ready, ovf};
  wire [31:0] rd_mux =
    reg_addr == `CPC_REG_CTRL ? {17'h0_0000, ctrl} :
    reg_addr == `CPC_REG_MASK ? {16'h0000, mask} :
    reg_addr == `CPC_REG_SHIFT ? {28'h000_0000, shift} :
    reg_addr == `CPC_REG_XSTART ? {16'h0000, xs} :
    reg_addr == `CPC_REG_YSTART ? {16'h0000, ys} :
    reg_addr == `CPC_REG_WIDTH ? {16'h0000, win_w} :
    reg_addr == `CPC_REG_HEIGHT ? {16'h0000, win_h} :
    reg_addr == `CPC_REG_LUTA ? {16'h0000, lut_addr} :
    reg_addr == `CPC_REG_STAT ? stat_w : 32'h0000_0000;

  // Data valid only the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst || !reg_rd) reg_rdata <= 32'h0000_0000;
    else reg_rdata <= rd_mux;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_OVF_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
    push && !wr.ready ##1 !ovf_clr |=> ovf) else $error("drop without sticky overflow");
  AST_WHOLE_WORD: assert property (@(posedge sys_clk) disable iff (rst)
    wr.valid |-> $past(v2) && $past(last)) else $error("partial word pushed");
  AST_FLOW: assert property (@(posedge sys_clk) disable iff (rst)
    take |=> v1 ##1 v2) else $error("pixel lost between stages");
  AST_MASK: assert property (@(posedge sys_clk) disable iff (rst)
    $past(take) && !$past(tap2) && !$past(msb) |-> (idx & ~$past(mask)) == 16'h0000)
    else $error("masked bits reached table");
  AST_WIN: assert property (@(posedge sys_clk) disable iff (rst)
    take && roi_en |-> x >= xs && y >= ys && dx < win_w) else $error("pixel outside window");
  AST_SUB: assert property (@(posedge sys_clk) disable iff (rst)
    take && sub_en |-> (x & sub_m) == 16'h0000) else $error("decimation kept wrong pixel");
  AST_EDGE: assert property (@(posedge sys_clk) disable iff (rst)
    take |-> (fall ? !ps2 && ps3 : ps2 && !ps3)) else $error("sampled on wrong edge");
  AST_CLK_HALF: assert property (@(posedge sys_clk) disable iff (rst)
    ckout && $past(ckout) && ck_half > 6'h01 && $changed(pclk_o) |=> $stable(pclk_o))
    else $error("driven clock half period too short");
  AST_OE: assert property (@(posedge sys_clk) disable iff (rst)
    ckout ##1 ckout |-> !pclk_oe_n) else $error("pixel clock not driven");
endmodule : cpc_top
`default_nettype wire

// ===== rtl/cpc_wr_if.sv
// Purpose: Packed-word path from the packer into the buffer
// Assumes: Both ends on sys_clk
// Notes: ready low means the word offered is dropped
`timescale 1ns/1ps
`default_nettype none
interface cpc_wr_if;
  logic valid;
  cpc_pkg::cpc_word_t data;
  logic ready;
  cpc_pkg::cpc_level_t level;
  modport src (output valid, output data, input ready, input level);
  modport snk (input valid, input data, output ready, output level);
endinterface : cpc_wr_if
`default_nettype wire
